/* File: hdl/nmc_pkg.sv */
// Package of constants and types for the margin level command sequencer
package nmc_pkg;
  // ********************************************************************
  // Register map (word addresses on the plain register port)
  // ********************************************************************
  localparam logic [3:0] NMC_ADR_STAT = 4'h0;   // Status: complete, access error, violation, margin status
  localparam logic [3:0] NMC_ADR_IDX = 4'h1;    // Parameter index field
  localparam logic [3:0] NMC_ADR_PARAM = 4'h2;  // Parameter word at the current index
  localparam logic [3:0] NMC_ADR_MODE = 4'h3;   // Operating mode: bit 0 special mode
  localparam logic [3:0] NMC_ADR_LVL = 4'h4;    // Margin levels of both blocks (read only)
  localparam logic [3:0] NMC_ADR_IRQS = 4'h5;   // Sticky event status (read only)
  localparam logic [3:0] NMC_ADR_IRQC = 4'h6;   // Event clear (write only)
  localparam logic [3:0] NMC_ADR_IRQE = 4'h7;   // Event enable
  // ********************************************************************
  // Status register bit positions
  // ********************************************************************
  localparam int NMC_ST_CCF = 7;   // Command complete flag
  localparam int NMC_ST_AERR = 5;  // Access error flag
  localparam int NMC_ST_PVIO = 4;  // Protection violation flag
  localparam int NMC_ST_MGH = 1;   // Margin check status high
  localparam int NMC_ST_MGL = 0;   // Margin check status low
  // ********************************************************************
  // Command codes and parameter values
  // ********************************************************************
  localparam logic [7:0] NMC_CMD_USER = 8'h0D;   // User margin command code
  localparam logic [7:0] NMC_CMD_FIELD = 8'h0E;  // Field margin command code
  localparam logic [2:0] NMC_IDX_LAST = 3'h2;    // Index required at launch
  localparam logic [15:0] NMC_LVL_NORMAL = 16'h0000;  // Normal reads
  localparam logic [15:0] NMC_LVL_ERASED = 16'h0001;  // Margin toward erased
  localparam logic [15:0] NMC_LVL_PROG = 16'h0002;    // Margin toward programmed
  // Global address windows of the two blocks
  localparam logic [23:0] NMC_DF_LO = 24'h100000;  // Data flash first address
  localparam logic [23:0] NMC_DF_HI = 24'h1007FF;  // Data flash last address
  localparam logic [23:0] NMC_PF_LO = 24'hFE0000;  // Program flash first address
  localparam logic [23:0] NMC_PF_HI = 24'hFFFFFF;  // Program flash last address
  // Event bits
  localparam int NMC_EV_DONE = 0;  // Command finished
  localparam int NMC_EV_ERR = 1;   // Command rejected
  localparam int NMC_EV_W = 2;     // Event count
  // Sequencer states
  typedef enum logic [1:0] {NMC_IDLE, NMC_CHECK, NMC_APPLY} nmc_state_e;
endpackage : nmc_pkg

/* File: hdl/nmc_lvl_if.sv */
// Interface carrying a margin level update into a level holder
`timescale 1ns/100ps
interface nmc_lvl_if;
  logic wr;           // One-cycle update strobe
  logic [1:0] level;  // Level to store
  logic [1:0] held;   // Level in force
  modport src (output wr, output level, input held);
  modport dst (input wr, input level, output held);
endinterface : nmc_lvl_if

/* File: hdl/nmc_lvl_hold.sv */
// Margin level holder for one memory block
`timescale 1ns/100ps
module nmc_lvl_hold (
  input wire logic clk,
  input wire logic rst,
  nmc_lvl_if.dst lvl
);
  import nmc_pkg::*;
  // ********************************************************************
  // Level register
  // ********************************************************************
  // Level persists until the next accepted command for this block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl.held <= NMC_LVL_NORMAL[1:0];
    end else if (lvl.wr) begin
      lvl.held <= lvl.level;
    end
  end
endmodule // nmc_lvl_hold

/* File: hdl/nmc_seq.sv */
// Margin level command sequencer with register port and interrupt
// Notes on behaviour
// - Access error unless index is 010
// - Access error if mode lacks the command
// - Access error on invalid 24-bit block address
// - Access error on invalid margin value
// - Field margin accepted only in special mode
// - Level governs later reads until changed
// - Clearing complete flag launches; flag sets after apply
`timescale 1ns/100ps
module nmc_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [1:0] pf_level,
  output logic [1:0] df_level,
  output logic irq
);
  import nmc_pkg::*;
  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [15:0] param [0:2];  // Command parameter words
  logic [2:0] idx;           // Parameter index field
  logic ccf;                 // Command complete flag
  logic aerr;                // Access error flag
  logic pvio;                // Protection violation flag, never set here
  logic [1:0] mgst;          // Margin check status, never set here
  logic special;             // Special operating mode
  logic [NMC_EV_W-1:0] ev_stat;  // Sticky events
  logic [NMC_EV_W-1:0] ev_en;    // Event enables
  nmc_state_e state;
  logic [15:0] rdata_q;
  nmc_lvl_if pf_if ();
  nmc_lvl_if df_if ();
  // ********************************************************************
  // Decode
  // ********************************************************************
  wire wr_stat = reg_wr && reg_addr == NMC_ADR_STAT;
  wire wr_idx = reg_wr && reg_addr == NMC_ADR_IDX;
  wire wr_param = reg_wr && reg_addr == NMC_ADR_PARAM;
  wire wr_mode = reg_wr && reg_addr == NMC_ADR_MODE;
  wire wr_irqc = reg_wr && reg_addr == NMC_ADR_IRQC;
  wire wr_irqe = reg_wr && reg_addr == NMC_ADR_IRQE;
  // Launch: write one to the complete flag while it is set
  wire launch = wr_stat && reg_wdata[NMC_ST_CCF] && ccf;
  // Error flags are write-one-to-clear, only while idle
  wire clr_aerr = wr_stat && reg_wdata[NMC_ST_AERR] && ccf;
  wire clr_pvio = wr_stat && reg_wdata[NMC_ST_PVIO] && ccf;
  // Parameter words may only change while no command is running
  wire param_ok = ccf && idx <= NMC_IDX_LAST;
  // ********************************************************************
  // Checks made at launch
  // ********************************************************************
  // Parameter words split into code, block address and margin
  wire [7:0] cmd_code = param[0][15:8];
  wire [23:0] gaddr = {param[0][7:0], param[1]};
  wire [15:0] margin = param[2];
  wire is_user = cmd_code == NMC_CMD_USER;
  wire is_field = cmd_code == NMC_CMD_FIELD;
  wire in_df = gaddr >= NMC_DF_LO && gaddr <= NMC_DF_HI;
  wire in_pf = gaddr >= NMC_PF_LO && gaddr <= NMC_PF_HI;
  // Each failing check alone is enough to refuse the command
  wire bad_idx = idx != NMC_IDX_LAST;
  wire bad_mode = !(is_user || (is_field && special));
  wire bad_addr = !(in_df || in_pf);
  wire bad_lvl = margin != NMC_LVL_NORMAL && margin != NMC_LVL_ERASED
                 && margin != NMC_LVL_PROG;
  wire chk_fail = bad_idx || bad_mode || bad_addr || bad_lvl;
  // ********************************************************************
  // Sequencer
  // ********************************************************************
  nmc_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      NMC_IDLE: begin
        if (launch) begin
          next_state = NMC_CHECK;
        end
      end
      NMC_CHECK: begin
        next_state = NMC_APPLY;
      end
      NMC_APPLY: begin
        next_state = NMC_IDLE;
      end
      default: begin
        next_state = NMC_IDLE;  // Unused code falls back to idle
      end
    endcase
  end
  // Checks are judged in the single cycle after launch
  wire in_check = state == NMC_CHECK;
  wire apply_ok = in_check && !chk_fail;
  wire apply_bad = in_check && chk_fail;
  wire done = state == NMC_APPLY;
  // Level update strobes toward the block holders
  assign pf_if.wr = apply_ok && in_pf;
  assign df_if.wr = apply_ok && in_df;
  assign pf_if.level = margin[1:0];
  assign df_if.level = margin[1:0];
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= NMC_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Complete flag: cleared by launch, set again after the apply step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ccf <= 1'b1;
    end else if (done) begin
      ccf <= 1'b1;
    end else if (launch) begin
      ccf <= 1'b0;
    end
  end
  // Access error: set by failed checks; the set wins over a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aerr <= 1'b0;
    end else if (apply_bad) begin
      aerr <= 1'b1;
    end else if (clr_aerr) begin
      aerr <= 1'b0;
    end
  end
  // Margin commands never touch these flags; no other source here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pvio <= 1'b0;
      mgst <= 2'b00;
    end else if (clr_pvio) begin
      pvio <= 1'b0;
    end
  end
  // Index, mode and parameter words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx <= 3'h0;
      special <= 1'b0;
    end else begin
      if (wr_idx && ccf) begin
        idx <= reg_wdata[2:0];
      end
      if (wr_mode) begin
        special <= reg_wdata[0];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      param[0] <= 16'h0000;
      param[1] <= 16'h0000;
      param[2] <= 16'h0000;
    end else if (wr_param && param_ok) begin
      param[idx[1:0]] <= reg_wdata;
    end
  end
  // ********************************************************************
  // Interrupts
  // ********************************************************************
  // Done and error events come straight from the sequencer
  wire [NMC_EV_W-1:0] ev_set = {apply_bad, done};
  wire [NMC_EV_W-1:0] ev_clr = wr_irqc ? reg_wdata[NMC_EV_W-1:0] : '0;
  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat <= '0;
      ev_en <= '0;
      irq <= 1'b0;
    end else begin
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
      if (wr_irqe) begin
        ev_en <= reg_wdata[NMC_EV_W-1:0];
      end
      irq <= |(((ev_stat & ~ev_clr) | ev_set) & (wr_irqe ? reg_wdata[NMC_EV_W-1:0] : ev_en));
    end
  end
  // ********************************************************************
  // Read port
  // ********************************************************************
  // Status word built from the package bit positions; unused bits read zero
  wire [15:0] stat_word = (16'(ccf) << NMC_ST_CCF)
                          | (16'(aerr) << NMC_ST_AERR)
                          | (16'(pvio) << NMC_ST_PVIO)
                          | (16'(mgst[1]) << NMC_ST_MGH)
                          | (16'(mgst[0]) << NMC_ST_MGL);
  // An index past the last word reads zero rather than aliasing a stored word
  wire [15:0] param_rd = idx <= NMC_IDX_LAST ? param[idx[1:0]] : 16'h0000;
  // Write-only and unmapped addresses fall through to zero
  wire [15:0] rd_mux =
    reg_addr == NMC_ADR_STAT ? stat_word :
    reg_addr == NMC_ADR_IDX ? {13'h0000, idx} :
    reg_addr == NMC_ADR_PARAM ? param_rd :
    reg_addr == NMC_ADR_MODE ? {15'h0000, special} :
    reg_addr == NMC_ADR_LVL ? {12'h000, df_if.held, pf_if.held} :
    reg_addr == NMC_ADR_IRQS ? {14'h0000, ev_stat} :
    reg_addr == NMC_ADR_IRQE ? {14'h0000, ev_en} : 16'h0000;
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;
  // Level outputs registered again so top outputs come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_level <= NMC_LVL_NORMAL[1:0];
      df_level <= NMC_LVL_NORMAL[1:0];
    end else begin
      pf_level <= pf_if.held;
      df_level <= df_if.held;
    end
  end
  // One holder per block keeps its level between commands
  nmc_lvl_hold u_pf (
    .clk(clk),
    .rst(rst),
    .lvl(pf_if.dst)
  );
  nmc_lvl_hold u_df (
    .clk(clk),
    .rst(rst),
    .lvl(df_if.dst)
  );
  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence s_launch;
    launch;
  endsequence
  // Launch timing: busy for two cycles, complete again on the third
  sequence s_finish;
    !ccf ##1 ccf;
  endsequence
  // Parameter set that every launch check must accept for the user command
  sequence s_user_good;
    in_check && is_user && idx == NMC_IDX_LAST && (in_pf || in_df) && margin <= NMC_LVL_PROG;
  endsequence
  a_launch_complete: assert property (@(posedge clk) disable iff (rst) s_launch |=> !ccf ##1 s_finish)
    else $error("complete flag not restored three cycles after launch");
  a_done_event: assert property (@(posedge clk) disable iff (rst)
    s_launch |-> ##3 (ccf && ev_stat[NMC_EV_DONE]))
    else $error("done event missing after launch");
  a_busy_index: assert property (@(posedge clk) disable iff (rst) wr_idx && !ccf |=> $stable(idx))
    else $error("index changed while a command was running");
  // Each launch check on its own must raise the access error
  a_idx_error: assert property (@(posedge clk) disable iff (rst)
    launch && idx != NMC_IDX_LAST |-> ##2 aerr)
    else $error("bad index did not raise access error");
  a_field_mode: assert property (@(posedge clk) disable iff (rst)
    in_check && is_field && !special |=> aerr && $stable(pf_level) ##1 $stable(pf_level))
    else $error("field command ran outside special mode");
  a_user_mode: assert property (@(posedge clk) disable iff (rst)
    in_check && !is_user && !is_field |=> aerr)
    else $error("unknown command did not raise access error");
  a_addr_error: assert property (@(posedge clk) disable iff (rst)
    in_check && !in_pf && !in_df |=> aerr)
    else $error("bad address did not raise access error");
  a_level_error: assert property (@(posedge clk) disable iff (rst)
    in_check && margin > NMC_LVL_PROG |=> aerr)
    else $error("bad margin did not raise access error");
  // A refused command leaves both block levels as they were
  a_error_hold: assert property (@(posedge clk) disable iff (rst)
    apply_bad |=> $stable(pf_if.held) && $stable(df_if.held))
    else $error("refused command changed a block level");
  // A clean user command must not be refused, in any mode
  a_user_accept: assert property (@(posedge clk) disable iff (rst)
    s_user_good |=> $stable(aerr))
    else $error("valid user command raised access error");
  // Field command in special mode reaches the addressed block
  a_field_accept: assert property (@(posedge clk) disable iff (rst)
    in_check && is_field && special && idx == NMC_IDX_LAST && (in_pf || in_df) && margin <= NMC_LVL_PROG
    |-> ##2 (in_pf ? pf_level : df_level) == margin[1:0])
    else $error("field command in special mode not applied");
  // Accepted levels reach the outputs two cycles after the check
  a_level_apply: assert property (@(posedge clk) disable iff (rst)
    apply_ok && in_pf |-> ##2 pf_level == margin[1:0])
    else $error("program flash level not applied");
  a_df_apply: assert property (@(posedge clk) disable iff (rst)
    apply_ok && in_df |-> ##2 df_level == margin[1:0])
    else $error("data flash level not applied");
  a_level_keep: assert property (@(posedge clk) disable iff (rst)
    !pf_if.wr |-> ##2 $stable(pf_level))
    else $error("program flash level changed without a command");
  a_flags_untouched: assert property (@(posedge clk) disable iff (rst)
    !clr_pvio |=> $stable(pvio) && mgst == 2'b00)
    else $error("margin command touched other status flags");
endmodule // nmc_seq

/* File: tb/nmc_seq_tb_top.sv */
// Self-checking testbench for the margin level command sequencer
`timescale 1ns/100ps
module nmc_seq_tb_top;
  import nmc_pkg::*;
  // ********************************************************************
  // Stimulus signals and bookkeeping
  // ********************************************************************
  logic clk = 1'b0;  // 25 MHz bus clock
  logic rst = 1'b1;  // Asynchronous reset, held at start
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] pf_level;
  logic [1:0] df_level;
  logic irq;
  int fails = 0;  // Mismatch count
  int check_count = 0;  // Comparison count
  integer seed = 32'h0C63B4B0;  // Fixed seed keeps runs repeatable
  logic [1:0] m_pf = 2'h0;  // Expected program flash level
  logic [1:0] m_df = 2'h0;  // Expected data flash level
  logic [15:0] rdv;  // Last read data
  logic [7:0] code;
  logic [23:0] addr;
  logic [15:0] margin;
  logic [2:0] idx;
  logic spec;
  logic [1:0] en;
  logic err;

  nmc_seq dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pf_level(pf_level), .df_level(df_level), .irq(irq));

  // Clock toggles every half period
  always #20 clk = ~clk;

  // ********************************************************************
  // Bus tasks, compares and expectation functions
  // ********************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rdv = reg_rdata;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic in_df(input logic [23:0] a);
    return (a >= NMC_DF_LO) && (a <= NMC_DF_HI);
  endfunction

  function automatic logic in_pf(input logic [23:0] a);
    return (a >= NMC_PF_LO) && (a <= NMC_PF_HI);
  endfunction

  // Word the parameter port shows at an index; nothing past the last word
  function automatic logic [15:0] exp_param(input logic [2:0] i);
    case (i)
      3'h0: return {code, addr[23:16]};
      3'h1: return addr[15:0];
      3'h2: return margin;
      default: return 16'h0000;
    endcase
  endfunction

  // Any failed launch check yields the access error
  function automatic logic exp_err(input logic [7:0] c, input logic [23:0] a, input logic [15:0] m,
    input logic [2:0] i, input logic s);
    logic code_ok;
    code_ok = (c == NMC_CMD_USER) || ((c == NMC_CMD_FIELD) && s);
    return (i != NMC_IDX_LAST) || !code_ok || !(in_df(a) || in_pf(a)) || (m > NMC_LVL_PROG);
  endfunction

  task automatic end_sim;
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: a full run needs far fewer cycles than this
  initial begin
    #(40 * 20000);
    fails++;
    end_sim();
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(NMC_ADR_STAT);
    chk_reg(rdv, 16'h0080);
    rd(NMC_ADR_LVL);
    chk_reg(rdv, 16'h0000);
    rd(4'hF);
    chk_reg(rdv, 16'h0000);
    chk_out({1'b0, irq}, 2'h0);
    for (int n = 0; n < 60; n++) begin
      // Mix legal and broken commands, with window edges as addresses
      case ({$random(seed)} % 4)
        0: code = NMC_CMD_FIELD;
        1: code = 8'($random(seed));
        default: code = NMC_CMD_USER;
      endcase
      case ({$random(seed)} % 8)
        0: addr = NMC_DF_LO;
        1: addr = NMC_DF_HI;
        2: addr = NMC_DF_HI + 24'h000001;
        3: addr = NMC_PF_LO - 24'h000001;
        4: addr = NMC_PF_LO;
        5: addr = NMC_PF_HI;
        default: addr = 24'($random(seed));
      endcase
      margin = 16'({$random(seed)} % 4);
      idx = ({$random(seed)} % 4 == 0) ? 3'($random(seed)) : NMC_IDX_LAST;
      spec = 1'($random(seed));
      en = 2'($random(seed));
      // Corner case first: field command in special mode at the program flash base
      if (n == 0) begin
        code = NMC_CMD_FIELD;
        addr = NMC_PF_LO;
        margin = NMC_LVL_PROG;
        idx = NMC_IDX_LAST;
        spec = 1'b1;
      end
      wr(NMC_ADR_MODE, {15'h0000, spec});
      wr(NMC_ADR_IRQE, {14'h0000, en});
      wr(NMC_ADR_IDX, 16'h0000);
      wr(NMC_ADR_PARAM, {code, addr[23:16]});
      wr(NMC_ADR_IDX, 16'h0001);
      wr(NMC_ADR_PARAM, addr[15:0]);
      wr(NMC_ADR_IDX, 16'h0002);
      wr(NMC_ADR_PARAM, margin);
      wr(NMC_ADR_IDX, {13'h0000, idx});
      wr(NMC_ADR_STAT, 16'h0080);
      // Index write lands while busy and must be ignored
      wr(NMC_ADR_IDX, 16'h0007);
      repeat (3) @(posedge clk);
      err = exp_err(code, addr, margin, idx, spec);
      if (!err && in_df(addr)) begin
        m_df = margin[1:0];
      end else if (!err) begin
        m_pf = margin[1:0];
      end
      rd(NMC_ADR_STAT);
      chk_reg(rdv, err ? 16'h00A0 : 16'h0080);
      rd(NMC_ADR_LVL);
      chk_reg(rdv, {12'h000, m_df, m_pf});
      chk_out(pf_level, m_pf);
      chk_out(df_level, m_df);
      rd(NMC_ADR_IRQS);
      chk_reg(rdv, {14'h0000, err, 1'b1});
      chk_out({1'b0, irq}, {1'b0, |(en & {err, 1'b1})});
      rd(NMC_ADR_IDX);
      chk_reg(rdv, {13'h0000, idx});
      rd(NMC_ADR_PARAM);
      chk_reg(rdv, exp_param(idx));
      rd(NMC_ADR_MODE);
      chk_reg(rdv, {15'h0000, spec});
      rd(NMC_ADR_IRQE);
      chk_reg(rdv, {14'h0000, en});
      // Clear sticky error and events before the next command
      wr(NMC_ADR_STAT, 16'h0020);
      wr(NMC_ADR_IRQC, 16'h0003);
      repeat (2) @(posedge clk);
      chk_out({1'b0, irq}, 2'h0);
      rd(NMC_ADR_STAT);
      chk_reg(rdv, 16'h0080);
    end
    end_sim();
  end
endmodule // nmc_seq_tb_top
